// *** src/sss_consts.vh ***
// Register offsets, field positions, reset values and timing for the serial shift unit
`ifndef SSS_CONSTS_VH
`define SSS_CONSTS_VH
`define SSS_ADDR_CTRL      2'h0
`define SSS_ADDR_STAT      2'h1
`define SSS_ADDR_DATA_U    2'h2
`define SSS_ADDR_DATA_L    2'h3
`define SSS_CTRL_RESET     8'h00
`define SSS_STAT_RESET     8'h9c
`define SSS_STAT_FIXED     8'h9c
`define SSS_BIT_LEVEL      6
`define SSS_BIT_OVERRUN    5
`define SSS_BIT_TAIL       1
`define SSS_BIT_START      0
`define SSS_BIT_MODE_HI    7
`define SSS_BIT_MODE_LO    6
`define SSS_BIT_MARK_EN    5
`define SSS_BIT_LATCH      4
`define SSS_BIT_CLK_SRC    3
`define SSS_MODE_8BIT      2'h0
`define SSS_MODE_16BIT     2'h1
`define SSS_MODE_CONT      2'h2
`define SSS_BITS_8         5'h08
`define SSS_BITS_16        5'h10
`define SSS_TAIL_HALVES    2'h2
`endif

// *** src/sss_shift_unit.v ***
// Synchronous serial shift unit: registers, clock divider, shifter, flags
// How it works
// (RL1) Status register resets to 9c with all live flags clear.
// (RL2) Status bit 7 always reads one; writes ignored.
// (RL3) Status bits 4..2 read one to match reset value; writes ignored.
// (RL4) Writing idle level drives the data output pin at once.
// (RL5) Reading idle level returns the live data output pin level.
// (RL6) Idle level holds until next transfer; then last bit stays driven.
// (RL7) Software must not write status during a transfer.
// (RL8) External clock rising edge after completion sets the overrun flag.
// (RL9) Overrun clears only by writing zero after reading it as one.
// (RL10) Tail flag reads one only while tail marker is sent.
// (RL11) Writing one to start begins a transfer except in mode 10; zero ignored.
// (RL12) Start flag stays one until the transfer completes: busy.
// (RL13) Eight and sixteen bit words using upper and lower registers.
// (RL14) Sixteen bit: upper shifts into lower; input enters upper MSB.
// (RL15) Eight bit: lower shifts out LSB first, input enters its MSB.
// (RL16) Data registers valid only after completion; no reset value.
// (RL17) Internal source drives clock pin; external source makes it input.
// (RL18) Mode 10 drives the prescaler clock continuously on the clock pin; only with internal source, external keeps the pin an input.
// (RL19) Transmit bit changes on falling edge, holds to next rising edge.
// (RL20) Receive data is sampled on rising serial clock edge.
// (RL21) Mode field: 00 eight bit, 01 sixteen bit, 10 continuous clock.
// (RL22) Clock source bit and three bit prescaler ratio 1024 down to 2.
// (RL23) Any control write during a transfer stops it.
// (RL24) Internal clock stops at completion until start is set again.
// (RL25) Divider counter makes clock rates; bit counter detects completion.
`timescale 1ns/10ps
`include "sss_consts.vh"
module sss_shift_unit (
  input  wire       sys_clk,
  input  wire       resetn,
  input  wire [1:0] reg_addr,
  input  wire [7:0] reg_wdata,
  input  wire       reg_wr,
  input  wire       reg_rd,
  output reg  [7:0] reg_rdata,
  input  wire       serial_clock_pin_in,
  output reg        serial_clock_pin_out,
  output reg        serial_clock_pin_oe,
  input  wire       serial_data_in_pin,
  output reg        serial_data_out_pin
);
  localparam [3:0] ST_IDLE  = 4'h1;
  localparam [3:0] ST_SHIFT = 4'h2;
  localparam [3:0] ST_TAIL  = 4'h4;
  localparam [3:0] ST_DONE  = 4'h8;

  reg  [7:0]  ctrl_q;
  reg  [7:0]  data_u_q;
  reg  [7:0]  data_l_q;
  reg         overrun_flag_q;
  reg         overrun_seen_q;
  reg         start_busy_flag_q;
  reg  [3:0]  state_q;
  reg  [4:0]  bit_cnt_q;
  reg  [1:0]  tail_cnt_q;
  reg  [9:0]  div_q;
  reg         int_clk_q;
  reg         sck_meta_q;
  reg         sck_sync_q;
  reg         sck_prev_q;
  reg         din_meta_q;
  reg         din_sync_q;
  reg         armed_q;

  wire [1:0]  mode_sel      = ctrl_q[`SSS_BIT_MODE_HI:`SSS_BIT_MODE_LO];
  wire        tail_marker_enable = ctrl_q[`SSS_BIT_MARK_EN];
  wire        clock_source_select = ctrl_q[`SSS_BIT_CLK_SRC];
  wire        wide_mode     = (mode_sel == `SSS_MODE_16BIT); // [RL21]
  wire [4:0]  word_bits     = wide_mode ? `SSS_BITS_16 : `SSS_BITS_8;
  wire        wr_ctrl       = reg_wr && (reg_addr == `SSS_ADDR_CTRL);
  wire        wr_stat       = reg_wr && (reg_addr == `SSS_ADDR_STAT);
  wire        busy          = (state_q == ST_SHIFT);
  // A rise seen before the first fall is not a bit: the peer never saw it
  wire        shift_now     = busy && ser_rise && armed_q;
  wire        tail_marker_active = (state_q == ST_TAIL);
  reg  [3:0]  div_idx;
  reg         int_rise;
  reg         int_fall;
  reg         ser_rise;
  reg         ser_fall;

  // Divider tap for the selected prescaler ratio
  always @* begin
    case (ctrl_q[2:0]) // [RL22]
      3'h0:    div_idx = 4'h9;
      3'h1:    div_idx = 4'h7;
      3'h2:    div_idx = 4'h5;
      3'h3:    div_idx = 4'h4;
      3'h4:    div_idx = 4'h3;
      3'h5:    div_idx = 4'h2;
      3'h6:    div_idx = 4'h1;
      default: div_idx = 4'h0;
    endcase
  end

  // Serial clock edges from the divider or the synchronised pin
  always @* begin
    int_rise = 1'b0;
    int_fall = 1'b0;
    if (div_q[div_idx] != int_clk_q) begin
      int_rise = div_q[div_idx];
      int_fall = ~div_q[div_idx];
    end
    if (clock_source_select) begin // [RL22]
      ser_rise = sck_sync_q & ~sck_prev_q;
      ser_fall = ~sck_sync_q & sck_prev_q;
    end else begin
      ser_rise = int_rise;
      ser_fall = int_fall;
    end
  end

  // Pin synchronisers
  always @(posedge sys_clk) begin
    if (!resetn) begin
      sck_meta_q <= 1'b1;
      sck_sync_q <= 1'b1;
      sck_prev_q <= 1'b1;
      din_meta_q <= 1'b0;
      din_sync_q <= 1'b0;
    end else begin
      sck_meta_q <= serial_clock_pin_in;
      sck_sync_q <= sck_meta_q;
      sck_prev_q <= sck_sync_q;
      din_meta_q <= serial_data_in_pin;
      din_sync_q <= din_meta_q;
    end
  end

  // Prescaler counter on the system clock
  always @(posedge sys_clk) begin
    if (!resetn) begin
      div_q     <= 10'h000;
      int_clk_q <= 1'b0;
    end else begin
      div_q     <= div_q + 10'h001; // [RL25]
      int_clk_q <= div_q[div_idx];
    end
  end

  // Clock pin drive: idle high, toggles while shifting or in continuous mode
  always @(posedge sys_clk) begin
    if (!resetn) begin
      serial_clock_pin_out <= 1'b1;
      serial_clock_pin_oe  <= 1'b1;
    end else begin
      serial_clock_pin_oe <= ~clock_source_select; // [RL17]
      if (mode_sel == `SSS_MODE_CONT)
        serial_clock_pin_out <= ~div_q[div_idx]; // [RL18]
      else if (busy && (int_rise || int_fall))
        serial_clock_pin_out <= int_rise;
      else if (!busy)
        serial_clock_pin_out <= 1'b1; // [RL24]
    end
  end

  // Transfer sequencer, data output pin and status flags
  always @(posedge sys_clk) begin
    if (!resetn) begin
      ctrl_q              <= `SSS_CTRL_RESET;
      state_q             <= ST_IDLE;
      bit_cnt_q           <= 5'h00;
      tail_cnt_q          <= 2'h0;
      start_busy_flag_q   <= 1'b0; // [RL1]
      overrun_flag_q      <= 1'b0; // [RL1]
      overrun_seen_q      <= 1'b0;
      armed_q             <= 1'b0;
      serial_data_out_pin <= 1'b0; // [RL1]
    end else begin
      if (reg_rd && (reg_addr == `SSS_ADDR_STAT) && overrun_flag_q)
        overrun_seen_q <= 1'b1;
      if (wr_ctrl) begin
        ctrl_q  <= reg_wdata;
        state_q <= ST_IDLE; // [RL23]
        start_busy_flag_q <= 1'b0;
      end else if (wr_stat) begin
        if (reg_wdata[`SSS_BIT_START] && (mode_sel != `SSS_MODE_CONT)) begin // [RL11]
          serial_data_out_pin <= data_l_q[0]; // [RL6]
          start_busy_flag_q <= 1'b1; // [RL12]
          state_q   <= ST_SHIFT;
          bit_cnt_q <= 5'h00;
          armed_q   <= 1'b0;
        end else begin
          serial_data_out_pin <= reg_wdata[`SSS_BIT_LEVEL]; // [RL4]
        end
      end else begin
        case (state_q)
          ST_SHIFT: begin
            if (ser_fall) begin
              serial_data_out_pin <= data_l_q[0]; // [RL19] [RL6]
              armed_q <= 1'b1;
            end
            if (shift_now) begin
              bit_cnt_q <= bit_cnt_q + 5'h01; // [RL25]
              if (bit_cnt_q + 5'h01 == word_bits) begin
                start_busy_flag_q <= 1'b0; // [RL12]
                tail_cnt_q <= 2'h0;
                state_q <= tail_marker_enable ? ST_TAIL : ST_DONE;
              end
            end
          end
          ST_TAIL: begin
            if (int_rise || int_fall) begin
              tail_cnt_q <= tail_cnt_q + 2'h1;
              if (tail_cnt_q + 2'h1 == `SSS_TAIL_HALVES)
                state_q <= ST_DONE;
            end
          end
          ST_DONE: state_q <= ST_DONE;
          ST_IDLE: state_q <= ST_IDLE;
          default: state_q <= ST_IDLE;
        endcase
      end
      // Set beats the clear: a stray edge in the clearing cycle still flags
      if (clock_source_select && (state_q == ST_DONE) && ser_rise) begin
        overrun_flag_q <= 1'b1; // [RL8]
      end else if (wr_stat && !reg_wdata[`SSS_BIT_OVERRUN] && overrun_seen_q) begin
        overrun_flag_q <= 1'b0; // [RL9]
        overrun_seen_q <= 1'b0;
      end
    end
  end

  // Shift path; data registers are not reset
  always @(posedge sys_clk) begin
    if (reg_wr && (reg_addr == `SSS_ADDR_DATA_U) && !busy)
      data_u_q <= reg_wdata; // [RL16]
    else if (shift_now && wide_mode)
      data_u_q <= {din_sync_q, data_u_q[7:1]}; // [RL14] [RL20]
    if (reg_wr && (reg_addr == `SSS_ADDR_DATA_L) && !busy)
      data_l_q <= reg_wdata;
    else if (shift_now)
      data_l_q <= {wide_mode ? data_u_q[0] : din_sync_q, data_l_q[7:1]}; // [RL13] [RL15]
  end

  // Read port, data one cycle after the strobe
  always @(posedge sys_clk) begin
    if (!resetn) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        `SSS_ADDR_CTRL:   reg_rdata <= ctrl_q;
        `SSS_ADDR_STAT:   reg_rdata <= `SSS_STAT_FIXED // [RL2] [RL3]
                                     | {1'b0, serial_data_out_pin, overrun_flag_q, 3'h0,
                                        tail_marker_active, start_busy_flag_q}; // [RL5] [RL10]
        `SSS_ADDR_DATA_U: reg_rdata <= data_u_q;
        default:          reg_rdata <= data_l_q;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end
endmodule

// *** verification/sss_shift_unit_asserts.sv ***
// Port checker for the serial shift unit
`timescale 1ns/10ps
module sss_chk (
  input logic       sys_clk,
  input logic       resetn,
  input logic [1:0] reg_addr,
  input logic [7:0] reg_wdata,
  input logic       reg_wr,
  input logic       reg_rd,
  input logic [7:0] reg_rdata,
  input logic       serial_clock_pin_out,
  input logic       serial_clock_pin_oe,
  input logic       serial_data_out_pin
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  logic [7:0] ctrl_q;
  always @(posedge sys_clk)
    if (!resetn)
      ctrl_q <= 8'h00;
    else if (reg_wr && reg_addr == 2'h0)
      ctrl_q <= reg_wdata;
  sequence s_srd;
    reg_rd && reg_addr == 2'h1;
  endsequence
  sequence s_go;
    reg_wr && reg_addr == 2'h1 && reg_wdata[0] && ctrl_q[7:6] != 2'h2;
  endsequence
  a_stat_fixed: assert property (s_srd |=> reg_rdata[7] && reg_rdata[4:2] == 3'h7)
    else $error("reserved status bits wrong");
  a_level_read: assert property (s_srd |=> reg_rdata[6] == $past(serial_data_out_pin))
    else $error("level bit differs from pin");
  a_level_write: assert property (reg_wr && reg_addr == 2'h1 && !reg_wdata[0]
    |-> ##[1:2] serial_data_out_pin == $past(reg_wdata[6], 1)) else $error("pin level not set");
  a_clk_dir: assert property (reg_wr && reg_addr == 2'h0 |-> ##2
    serial_clock_pin_oe == !$past(reg_wdata[3], 2)) else $error("clock direction wrong");
  a_ctrl_back: assert property (reg_wr && reg_addr == 2'h0 ##1 reg_rd && reg_addr == 2'h0
    |=> reg_rdata == $past(reg_wdata, 2)) else $error("control readback wrong");
  a_start_busy: assert property (s_go ##2 s_srd |=> reg_rdata[0])
    else $error("busy not shown");
  a_cont_clk: assert property (ctrl_q == 8'h87 |-> ##[1:4] $changed(serial_clock_pin_out))
    else $error("clock not running");
  a_tx_fall: assert property ($changed(serial_data_out_pin) && serial_clock_pin_oe
    && !$past(reg_wr) && !$past(reg_wr, 2) |-> !serial_clock_pin_out) else $error("bit off edge");
endmodule
bind sss_shift_unit sss_chk u_chk (.sys_clk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
  .reg_rdata, .serial_clock_pin_out, .serial_clock_pin_oe, .serial_data_out_pin);

// *** verification/sss_peer.sv ***
// Far side serial peer: sends, captures and can make the clock
`timescale 1ns/10ps
module sss_peer (
  input  wire sys_clk,
  input  wire sck,
  input  wire sdo,
  output reg  sdi = 1'b1,
  output reg  sck_drv = 1'b1
);
  reg [15:0] tx_q = 16'h0000;
  reg [15:0] cap_q = 16'h0000;
  reg [3:0]  idx_q = 4'h0;
  always @(negedge sck) begin
    sdi <= tx_q[idx_q];
    idx_q <= idx_q + 4'h1;
  end
  always @(posedge sck)
    cap_q <= {sdo, cap_q[15:1]};
  task load(input [15:0] v);
    tx_q = v;
    idx_q = 4'h0;
    sdi = ~v[0];
  endtask
  task pulses(input integer n);
    repeat (n) begin
      @(posedge sys_clk);
      sck_drv <= 1'b0;
      repeat (8) @(posedge sys_clk);
      sck_drv <= 1'b1;
      repeat (7) @(posedge sys_clk);
    end
  endtask
endmodule

// *** verification/sss_shift_unit_tb_top.sv ***
// Testbench for the serial shift unit
`timescale 1ns/10ps
`define CHK(nm, ex, ac) begin n_tests++; if ((ac) !== (ex)) begin error_cnt++; \
  $display("[FAIL] %s exp %h got %h", nm, ex, ac); end end
module sss_shift_unit_tb_top;
  logic       sys_clk = 1'b0;
  logic       resetn = 1'b0;
  logic       reg_wr = 1'b0;
  logic       reg_rd = 1'b0;
  logic [1:0] reg_addr = 2'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] d;
  wire  [7:0] reg_rdata;
  wire        ck_o, ck_oe, sdo, sdi, ck_p;
  wire        sck = ck_oe ? ck_o : ck_p;
  int         error_cnt = 0, n_tests = 0, cyc = 0;
  always #4 sys_clk = ~sys_clk;
  sss_shift_unit u_dut (.sys_clk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .serial_clock_pin_in(sck), .serial_clock_pin_out(ck_o), .serial_clock_pin_oe(ck_oe),
    .serial_data_in_pin(sdi), .serial_data_out_pin(sdo));
  sss_peer u_peer (.sys_clk, .sck, .sdo, .sdi, .sck_drv(ck_p));
  task wr(input [1:0] a, input [7:0] v);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task rd(input [1:0] a);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(negedge sys_clk);
    d = reg_rdata;
  endtask
  task xfer(input [7:0] c, input [15:0] tx, input [15:0] rx);
    u_peer.load(rx);
    wr(2'h0, c);
    wr(2'h2, tx[15:8]);
    wr(2'h3, tx[7:0]);
    wr(2'h1, 8'h01);
    rd(2'h1);
    `CHK("busy", 1'b1, d[0])
    for (int i = 0; i < 300 && d[0]; i++) rd(2'h1);
    `CHK("done", 1'b0, d[0])
    `CHK("hold", c[6] ? tx[15] : tx[7], d[6])
    `CHK("tx", c[6] ? tx : tx[7:0], c[6] ? u_peer.cap_q : u_peer.cap_q[15:8])
    rd(2'h3);
    `CHK("rx_lo", rx[7:0], d)
    rd(2'h2);
    if (c[6]) `CHK("rx_hi", rx[15:8], d)
    $display("test xfer %h done", c);
  endtask
  task t_ext;
    u_peer.load(16'h00c3);
    wr(2'h0, 8'h08);
    repeat (2) @(negedge sys_clk);
    `CHK("oe", 1'b0, ck_oe)
    wr(2'h1, 8'h01);
    u_peer.pulses(9);
    rd(2'h1);
    `CHK("ovr", 8'hbc, d & 8'hbd)
    rd(2'h3);
    `CHK("ext_rx", 8'hc3, d)
    wr(2'h1, 8'h20);
    rd(2'h1);
    `CHK("ovr1", 1'b1, d[5])
    wr(2'h1, 8'h00);
    rd(2'h1);
    `CHK("ovr0", 1'b0, d[5])
    $display("test ext done");
  endtask
  task t_stop;
    wr(2'h0, 8'h00);
    wr(2'h1, 8'h01);
    wr(2'h0, 8'h00);
    rd(2'h1);
    `CHK("stop", 1'b0, d[0])
    wr(2'h0, 8'h87);
    wr(2'h1, 8'h01);
    rd(2'h1);
    `CHK("cont", 1'b0, d[0])
    wr(2'h0, 8'h00);
    $display("test stop done");
  endtask
  task conclude;
    $display("checks %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      conclude;
    end
  end
  initial begin
    repeat (4) @(posedge sys_clk);
    resetn <= 1'b1;
    rd(2'h1);
    `CHK("reset", 8'h9c, d)
    wr(2'h1, 8'h3c);
    rd(2'h1);
    `CHK("fixed", 8'h9c, d)
    wr(2'h1, 8'h40);
    rd(2'h1);
    `CHK("level", 8'hdc, d)
    `CHK("pin", 1'b1, sdo)
    $display("test regs done");
    xfer(8'h05, 16'h00a5, 16'h003c);
    xfer(8'h45, 16'h1234, 16'hbeef);
    t_ext;
    t_stop;
    conclude;
  end
endmodule
